// ---- ebat_access.sv ----
// access sequencer of the external memory interface
`timescale 1ns/10ps
`include "ebat_map.svh"
module ebat_access (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire ebat_pkg::ebat_zone_cfg_s zone_cfg,
  input  wire logic                    timing_half_rate,
  input  wire logic                    out_half_rate,
  input  wire logic                    req_valid,
  input  wire ebat_pkg::ebat_req_s     req,
  input  wire logic                    external_ready_in,
  output logic                         req_accept_reg,
  output logic                         access_done_reg,
  output logic                         zone_chip_select_n_reg,
  output logic                         read_strobe_n_reg,
  output logic                         write_strobe_n_reg,
  output logic                         read_not_write_reg,
  output logic [`EBAT_ADDR_W-1:0]      external_address_bus_reg,
  output logic                         external_output_clock_reg,
  output logic                         ready_async_mode_reg,
  output logic [`EBAT_WS_W-1:0]        hardware_wait_states_reg
);
  // scaled phase length: count, doubled when the doubling option is set
  function automatic logic [`EBAT_CNT_W-1:0] scale(input logic [`EBAT_ACT_W-1:0] c,
                                                   input logic dbl);
    logic [`EBAT_CNT_W-1:0] w;
    w = {{(`EBAT_CNT_W-`EBAT_ACT_W){1'b0}}, c};
    scale = dbl ? (w << 1) : w;
  endfunction

  function automatic ebat_pkg::ebat_phase_s pick(input ebat_pkg::ebat_zone_cfg_s z,
                                                 input logic wr);
    pick = wr ? z.wr : z.rd;
  endfunction

  ebat_pkg::ebat_state_e       state_reg, state_next;
  logic [`EBAT_CNT_W-1:0]      cnt_reg, cnt_next;
  logic [`EBAT_WS_W-1:0]       ws_next;
  logic [`EBAT_EL_W-1:0]       el_reg, el_next;
  ebat_pkg::ebat_phase_s       tm_reg, tm_next, tm_sel;
  logic                        dbl_reg, dbl_next, rdy_en_reg, rdy_en_next;
  logic                        wr_reg, wr_next, tick_reg, tick_next, phase_next;
  logic [`EBAT_ADDR_W-1:0]     addr_next, pend_reg, pend_next;
  logic                        accept_next, done_next, async_next;
  logic                        cs_n_next, rd_n_next, we_n_next, rnw_next, in_acc_next;
  logic                        rdy_meta_reg, rdy_sync_reg;

  // ready pin crosses in through two flops before anything reads it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdy_meta_reg <= 1'b0;
      rdy_sync_reg <= 1'b0;
    end else begin
      rdy_meta_reg <= external_ready_in;
      rdy_sync_reg <= rdy_meta_reg;
    end
  end

  // sequencer: moves only on timing clock ticks so every phase counts timing cycles
  always_comb begin
    tick_next   = timing_half_rate ? ~tick_reg : 1'b1;
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    ws_next     = hardware_wait_states_reg;
    el_next     = el_reg;
    tm_next     = tm_reg;
    dbl_next    = dbl_reg;
    rdy_en_next = rdy_en_reg;
    wr_next     = wr_reg;
    addr_next   = external_address_bus_reg;
    pend_next   = pend_reg;
    phase_next  = external_output_clock_reg;
    accept_next = 1'b0;
    done_next   = 1'b0;
    async_next  = zone_cfg.ready_enable & zone_cfg.ready_async_select;
    tm_sel      = pick(zone_cfg, req.write);
    if (tick_reg) begin
      phase_next = out_half_rate ? ~external_output_clock_reg : 1'b1;
      el_next    = el_reg + 8'h01;
      unique case (state_reg)
        ebat_pkg::EBAT_IDLE: begin
          if (req_valid) begin
            accept_next = 1'b1;
            tm_next     = tm_sel;
            dbl_next    = zone_cfg.timing_doubling;
            rdy_en_next = zone_cfg.ready_enable;
            wr_next     = req.write;
            pend_next   = req.addr;
            ws_next     = `EBAT_WS_RST;
            if (!phase_next) begin
              // old address stays on the bus through the alignment tick
              state_next = ebat_pkg::EBAT_ALIGN;
            end else begin
              addr_next  = req.addr;
              el_next    = `EBAT_EL_RST;
              state_next = ebat_pkg::EBAT_LEAD;
              cnt_next   = scale({1'b0, tm_sel.lead}, zone_cfg.timing_doubling) - 5'h01;
              if (tm_sel.lead == 2'h0) begin
                state_next = ebat_pkg::EBAT_ACTIVE;
                cnt_next   = scale(tm_sel.active, zone_cfg.timing_doubling);
              end
            end
          end
        end
        ebat_pkg::EBAT_ALIGN: begin
          addr_next  = pend_reg;
          el_next    = `EBAT_EL_RST;
          state_next = ebat_pkg::EBAT_LEAD;
          cnt_next   = scale({1'b0, tm_reg.lead}, dbl_reg) - 5'h01;
          if (tm_reg.lead == 2'h0) begin
            state_next = ebat_pkg::EBAT_ACTIVE;
            cnt_next   = scale(tm_reg.active, dbl_reg);
          end
        end
        ebat_pkg::EBAT_LEAD: begin
          cnt_next = cnt_reg - 5'h01;
          if (cnt_reg == `EBAT_CNT_RST) begin
            state_next = ebat_pkg::EBAT_ACTIVE;
            cnt_next   = scale(tm_reg.active, dbl_reg);
          end
        end
        ebat_pkg::EBAT_ACTIVE: begin
          cnt_next = cnt_reg - 5'h01;
          if (cnt_reg == `EBAT_CNT_RST) begin
            cnt_next = `EBAT_CNT_RST;
            // ready ignored when disabled, so waits stay zero then
            if (rdy_en_reg && !rdy_sync_reg) begin
              if (hardware_wait_states_reg != 8'hff) begin
                ws_next = hardware_wait_states_reg + 8'h01;
              end
            end else if (tm_reg.trail == 2'h0) begin
              state_next = ebat_pkg::EBAT_IDLE;
              done_next  = 1'b1;
            end else begin
              state_next = ebat_pkg::EBAT_TRAIL;
              cnt_next   = scale({1'b0, tm_reg.trail}, dbl_reg) - 5'h01;
            end
          end
        end
        ebat_pkg::EBAT_TRAIL: begin
          cnt_next = cnt_reg - 5'h01;
          if (cnt_reg == `EBAT_CNT_RST) begin
            state_next = ebat_pkg::EBAT_IDLE;
            done_next  = 1'b1;
          end
        end
      endcase
    end
  end

  // pin levels follow the next state, so they move with the tick that moves the state
  always_comb begin
    in_acc_next = (state_next == ebat_pkg::EBAT_LEAD) || (state_next == ebat_pkg::EBAT_ACTIVE)
                  || (state_next == ebat_pkg::EBAT_TRAIL);
    cs_n_next   = ~in_acc_next;
    rnw_next    = ~(in_acc_next & wr_next);
    rd_n_next   = ~((state_next == ebat_pkg::EBAT_ACTIVE) & ~wr_next);
    we_n_next   = ~((state_next == ebat_pkg::EBAT_ACTIVE) & wr_next);
  end

  // nothing checks the timing settings; illegal values simply run as programmed
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg                 <= ebat_pkg::EBAT_IDLE;
      cnt_reg                   <= `EBAT_CNT_RST;
      el_reg                    <= `EBAT_EL_RST;
      tm_reg                    <= '0;
      dbl_reg                   <= 1'b0;
      rdy_en_reg                <= 1'b0;
      wr_reg                    <= 1'b0;
      tick_reg                  <= 1'b1;
      req_accept_reg            <= 1'b0;
      access_done_reg           <= 1'b0;
      zone_chip_select_n_reg    <= 1'b1;
      read_strobe_n_reg         <= 1'b1;
      write_strobe_n_reg        <= 1'b1;
      read_not_write_reg        <= 1'b1;
      external_address_bus_reg  <= `EBAT_ADDR_RST;
      pend_reg                  <= `EBAT_ADDR_RST;
      external_output_clock_reg <= 1'b1;
      ready_async_mode_reg      <= 1'b0;
      hardware_wait_states_reg  <= `EBAT_WS_RST;
    end else begin
      state_reg                 <= state_next;
      cnt_reg                   <= cnt_next;
      el_reg                    <= el_next;
      tm_reg                    <= tm_next;
      dbl_reg                   <= dbl_next;
      rdy_en_reg                <= rdy_en_next;
      wr_reg                    <= wr_next;
      tick_reg                  <= tick_next;
      req_accept_reg            <= accept_next;
      access_done_reg           <= done_next;
      zone_chip_select_n_reg    <= cs_n_next;
      read_strobe_n_reg         <= rd_n_next;
      write_strobe_n_reg        <= we_n_next;
      read_not_write_reg        <= rnw_next;
      external_address_bus_reg  <= addr_next;
      pend_reg                  <= pend_next;
      external_output_clock_reg <= phase_next;
      ready_async_mode_reg      <= async_next;
      hardware_wait_states_reg  <= ws_next;
    end
  end

  // checks on the produced timing
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic [2:0] ctl_prev_reg;
  logic       ctl_changed;

  // chip-select and strobe levels of the previous edge, so the checks see which edge moved one of them
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_prev_reg <= 3'h7;
    end else begin
      ctl_prev_reg <= {zone_chip_select_n_reg, read_strobe_n_reg, write_strobe_n_reg};
    end
  end

  assign ctl_changed = {zone_chip_select_n_reg, read_strobe_n_reg, write_strobe_n_reg}
                       != ctl_prev_reg;

  sequence s_active_end;
    state_reg == ebat_pkg::EBAT_ACTIVE && cnt_reg == `EBAT_CNT_RST && tick_reg;
  endsequence

  property p_align_idle;
    state_reg == ebat_pkg::EBAT_ALIGN |-> zone_chip_select_n_reg && read_strobe_n_reg
      && write_strobe_n_reg && read_not_write_reg;
  endproperty
  a_align_idle: assert property (p_align_idle) else $error("control active in alignment");

  property p_start_rise;
    $fell(zone_chip_select_n_reg) |-> external_output_clock_reg && el_reg == `EBAT_EL_RST;
  endproperty
  a_start_rise: assert property (p_start_rise) else $error("access not on rising edge");

  property p_half_parity;
    out_half_rate && $past(out_half_rate) && ctl_changed |-> external_output_clock_reg == ~el_reg[0];
  endproperty
  a_half_parity: assert property (p_half_parity) else $error("edge parity wrong");

  property p_equal_rise;
    !out_half_rate && ctl_changed |-> external_output_clock_reg;
  endproperty
  a_equal_rise: assert property (p_equal_rise) else $error("edge not on rising output");

  property p_wait_extend;
    s_active_end and (rdy_en_reg && !rdy_sync_reg) |=> state_reg == ebat_pkg::EBAT_ACTIVE;
  endproperty
  a_wait_extend: assert property (p_wait_extend) else $error("active not extended");

  property p_ignore_ready;
    s_active_end and !rdy_en_reg |=> state_reg != ebat_pkg::EBAT_ACTIVE
      && hardware_wait_states_reg == `EBAT_WS_RST;
  endproperty
  a_ignore_ready: assert property (p_ignore_ready) else $error("ready not ignored");

  property p_addr_hold;
    zone_chip_select_n_reg |-> $stable(external_address_bus_reg);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved while idle");

  property p_tick_half;
    timing_half_rate && tick_reg |=> !tick_reg;
  endproperty
  a_tick_half: assert property (p_tick_half) else $error("timing tick too fast");
endmodule

// ---- ebat_map.svh ----
// constants of the external bus access sequencer: widths, reset values
`ifndef EBAT_MAP_SVH
`define EBAT_MAP_SVH
`define EBAT_ADDR_W   19
`define EBAT_LEAD_W   2
`define EBAT_ACT_W    3
`define EBAT_CNT_W    5
`define EBAT_WS_W     8
`define EBAT_EL_W     8
`define EBAT_ADDR_RST 19'h00000
`define EBAT_CNT_RST  5'h00
`define EBAT_WS_RST   8'h00
`define EBAT_EL_RST   8'h00
`endif

// ---- ebat_mem_model.sv ----
// far-side memory model that answers on the ready line
`timescale 1ns/10ps
module ebat_mem_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic slow,
  input  wire logic zone_chip_select_n,
  input  wire logic read_strobe_n,
  input  wire logic write_strobe_n,
  output logic      external_ready_in
);
  logic [5:0] low_cnt;
  logic       toggle_q;

  // counts strobe-low cycles; the line has no pull, so it wiggles when unselected
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= 6'h00;
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= ~toggle_q;
      if (read_strobe_n && write_strobe_n)
        low_cnt <= 6'h00;
      else if (low_cnt != 6'h3f)
        low_cnt <= low_cnt + 6'h01;
    end
  end

  // a slow device holds ready low for 40 strobe cycles, longer than any active phase
  assign external_ready_in = zone_chip_select_n ? toggle_q :
    !(slow && !(read_strobe_n && write_strobe_n) && low_cnt < 6'h28);
endmodule

// ---- ebat_pkg.sv ----
// types of the external bus access sequencer
`include "ebat_map.svh"
package ebat_pkg;
  typedef enum logic [2:0] {EBAT_IDLE, EBAT_ALIGN, EBAT_LEAD, EBAT_ACTIVE, EBAT_TRAIL} ebat_state_e;

  // lead, active and trail counts of one access direction
  typedef struct packed {
    logic [`EBAT_LEAD_W-1:0] lead;
    logic [`EBAT_ACT_W-1:0]  active;
    logic [`EBAT_LEAD_W-1:0] trail;
  } ebat_phase_s;

  // zone timing register contents
  typedef struct packed {
    ebat_phase_s rd;
    ebat_phase_s wr;
    logic        timing_doubling;
    logic        ready_enable;
    logic        ready_async_select;
  } ebat_zone_cfg_s;

  typedef struct packed {
    logic                    write;
    logic [`EBAT_ADDR_W-1:0] addr;
  } ebat_req_s;
endpackage

// ---- tb_top.sv ----
// self-checking bench of the external bus access sequencer
`timescale 1ns/10ps
`define EB_CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t: %s", $time, m); end end
module tb_top;
  typedef struct {logic wr; logic [18:0] addr; int l; int a; int t; int k;
    logic ohr; logic ren; logic asel; logic slow;} ebat_note_s;
  logic                     core_clk, reset_n, timing_half_rate, out_half_rate;
  logic                     req_valid, slow, ready, in_acc, stb, rise_seen, ph_fall, ph_rise;
  logic                     req_accept_reg, access_done_reg, zone_chip_select_n_reg;
  logic                     read_strobe_n_reg, write_strobe_n_reg, read_not_write_reg;
  logic                     external_output_clock_reg, ready_async_mode_reg;
  logic [18:0]              external_address_bus_reg, last_addr;
  logic [7:0]               hardware_wait_states_reg;
  logic [31:0]              seed, r;
  ebat_pkg::ebat_zone_cfg_s zone_cfg, cfg;
  ebat_pkg::ebat_req_s      req;
  ebat_pkg::ebat_phase_s    p;
  ebat_note_s               q[$], n, cur;
  int                       errors, n_tests, cycles, w, cs_cnt, st_cnt, lead_cnt, ws;

  ebat_access dut (.core_clk(core_clk), .reset_n(reset_n), .zone_cfg(zone_cfg),
    .timing_half_rate(timing_half_rate), .out_half_rate(out_half_rate),
    .req_valid(req_valid), .req(req), .external_ready_in(ready),
    .req_accept_reg(req_accept_reg), .access_done_reg(access_done_reg),
    .zone_chip_select_n_reg(zone_chip_select_n_reg), .read_strobe_n_reg(read_strobe_n_reg),
    .write_strobe_n_reg(write_strobe_n_reg), .read_not_write_reg(read_not_write_reg),
    .external_address_bus_reg(external_address_bus_reg),
    .external_output_clock_reg(external_output_clock_reg),
    .ready_async_mode_reg(ready_async_mode_reg),
    .hardware_wait_states_reg(hardware_wait_states_reg));
  ebat_mem_model u_mem (.core_clk(core_clk), .reset_n(reset_n), .slow(slow),
    .zone_chip_select_n(zone_chip_select_n_reg), .read_strobe_n(read_strobe_n_reg),
    .write_strobe_n(write_strobe_n_reg), .external_ready_in(ready));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // ready-honouring zones get only settings that software is allowed to use there
  function automatic ebat_pkg::ebat_phase_s mk_phase(logic [31:0] v, logic ren);
    ebat_pkg::ebat_phase_s ph;
    ph.lead = 2'(1 + v[7:0] % 3);
    ph.active = ren ? 3'(2 + v[15:8] % 6) : v[18:16];
    ph.trail = ren ? 2'h0 : v[20:19];
    return ph;
  endfunction

  task automatic print_verdict();
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // hang guard, generous against the longest expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // driver: one request per access, back to back after each done pulse except for the pause at each rate change every 16 requests
  initial begin
    seed = 32'hd22f7961;
    reset_n = 1'b0;
    zone_cfg = '0;
    timing_half_rate = 1'b0;
    out_half_rate = 1'b0;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      if (i[3:0] == 4'h0) begin
        repeat (4) @(posedge core_clk);
        {timing_half_rate, out_half_rate} <= 2'(i >> 4);
        @(posedge core_clk);
      end
      r = rnd();
      cfg.ready_enable = r[0];
      cfg.ready_async_select = r[1];
      cfg.timing_doubling = r[2];
      cfg.rd = mk_phase(rnd(), r[0]);
      cfg.wr = mk_phase(rnd(), r[0]);
      p = r[3] ? cfg.wr : cfg.rd;
      n = '{r[3], r[31:13], 32'(p.lead) << r[2], (32'(p.active) << r[2]) + 1,
        32'(p.trail) << r[2], timing_half_rate ? 2 : 1, out_half_rate, r[0], r[1], r[4]};
      zone_cfg <= cfg;
      slow <= r[4];
      req <= {r[3], r[31:13]};
      req_valid <= 1'b1;
      q.push_back(n);
      w = 0;
      while (req_accept_reg !== 1'b1 && w < 8) begin
        @(posedge core_clk);
        w++;
      end
      `EB_CHK(req_accept_reg, 1'b1, "request not accepted")
      req_valid <= 1'b0;
      w = 0;
      while (access_done_reg !== 1'b1 && w < 400) begin
        @(posedge core_clk);
        w++;
      end
    end
    repeat (8) @(posedge core_clk);
    print_verdict();
  end

  // monitor: pops the oldest note at chip-select fall, judges it at release
  always @(negedge core_clk) begin
    if (reset_n && !zone_chip_select_n_reg && !in_acc) begin
      cur = q.pop_front();
      in_acc = 1'b1;
      cs_cnt = 0;
      st_cnt = 0;
      lead_cnt = -1;
      rise_seen = 1'b0;
      last_addr = cur.addr;
      `EB_CHK(external_output_clock_reg, 1'b1, "access start phase")
      `EB_CHK(external_address_bus_reg, cur.addr, "address")
      `EB_CHK(ready_async_mode_reg, cur.ren & cur.asel, "ready mode")
    end
    if (reset_n && in_acc && !zone_chip_select_n_reg) begin
      stb = cur.wr ? write_strobe_n_reg : read_strobe_n_reg;
      `EB_CHK({cur.wr ? read_strobe_n_reg : write_strobe_n_reg, read_not_write_reg},
        {1'b1, !cur.wr}, "direction pins")
      if (!stb && st_cnt == 0) begin
        lead_cnt = cs_cnt;
        ph_fall = external_output_clock_reg;
      end
      if (stb && st_cnt != 0 && !rise_seen) begin
        rise_seen = 1'b1;
        ph_rise = external_output_clock_reg;
      end
      st_cnt += int'(!stb);
      cs_cnt++;
    end else if (reset_n && in_acc) begin
      in_acc = 1'b0;
      ws = (cur.ren && cur.slow) ? int'(hardware_wait_states_reg) : 0;
      if (!rise_seen)
        ph_rise = external_output_clock_reg;
      if (cur.ren && cur.slow) `EB_CHK(ws > 0 && ws <= 40, 1'b1, "wait count")
      else `EB_CHK(hardware_wait_states_reg, 8'h00, "unexpected waits")
      `EB_CHK(lead_cnt, cur.l * cur.k, "lead length")
      `EB_CHK(st_cnt, (cur.a + ws) * cur.k, "active length")
      `EB_CHK(cs_cnt, (cur.l + cur.a + ws + cur.t) * cur.k, "access length")
      `EB_CHK(access_done_reg, 1'b1, "done pulse")
      `EB_CHK(ph_fall, cur.ohr ? cur.l % 2 == 0 : 1'b1, "strobe on phase")
      `EB_CHK(ph_rise, cur.ohr ? (cur.l + cur.a + ws) % 2 == 0 : 1'b1, "strobe off phase")
      `EB_CHK(external_output_clock_reg, cur.ohr ? (cs_cnt / cur.k) % 2 == 0 : 1'b1,
        "release phase")
    end
    if (reset_n && zone_chip_select_n_reg) begin
      `EB_CHK({read_strobe_n_reg, write_strobe_n_reg, read_not_write_reg}, 3'b111,
        "idle pins")
      `EB_CHK(external_address_bus_reg, last_addr, "address hold")
    end
  end

  initial begin
    in_acc = 1'b0;
    last_addr = 19'h00000;
    errors = 0;
    n_tests = 0;
    cycles = 0;
  end
endmodule
